// ---- verilog/cmpirq_pkg.sv ----
// register map, field positions and reset values of the comparator bank
package cmpirq_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets; each comparator owns a pair, spaced by two
  localparam logic [3:0] OFF_MAIN1 = 4'h0;
  localparam logic [3:0] OFF_INIRQ1 = 4'h1;
  localparam logic [3:0] OFF_STRIDE = 4'h2;
  localparam logic [3:0] OFF_MIRROR = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h5;
  localparam logic [3:0] OFF_MASK = 4'h6;

  // main control fields
  localparam int MAIN_ON = 7;
  localparam int MAIN_RES = 6;
  localparam int MAIN_OE = 5;
  localparam int MAIN_INV = 4;
  localparam int MAIN_SPEED = 2;
  localparam int MAIN_HYS = 1;
  localparam int MAIN_SYNC = 0;
  localparam logic [7:0] MAIN_WMASK = 8'hB7;
  localparam logic [7:0] MAIN_RST = 8'h00;

  // input and interrupt control fields
  localparam int INIRQ_RISE = 7;
  localparam int INIRQ_FALL = 6;
  localparam int INIRQ_POS_LSB = 4;
  localparam int INIRQ_NEG_LSB = 0;
  localparam logic [7:0] INIRQ_WMASK = 8'hF3;
  localparam logic [7:0] INIRQ_RST = 8'h00;

  // positive input select code that ties the input to ground
  localparam logic [1:0] POS_SEL_GND = 2'h3;

  localparam logic [7:0] MIRROR_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

endpackage

// ---- verilog/cmpirq_channel.sv ----
// one comparator: polarity, sampled result and edge pulses
`timescale 1ns/1ps
module cmpirq_channel (
  input wire logic clock,
  input wire logic reset,
  input wire logic raw,
  input wire logic enable,
  input wire logic invert,
  output logic result,
  output logic rise,
  output logic fall
);

  logic result_ff;
  logic prev_ff;
  logic nxt_result;

  // a disabled comparator reads low, whatever the polarity
  assign nxt_result = enable & (raw ^ invert);
  // edges are taken between two clocked samples, so each counts once
  assign rise = result_ff & ~prev_ff;
  assign fall = ~result_ff & prev_ff;
  assign result = result_ff;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      result_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      result_ff <= nxt_result;
      prev_ff <= result_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  result_sense_a: assert property (
    enable && !invert |=> result_ff == $past(raw))
    else $error("result does not follow the input");

  result_inverted_a: assert property (
    enable && invert |=> result_ff == !$past(raw))
    else $error("inverted result does not oppose the input");

  edge_once_a: assert property (
    rise |=> !rise)
    else $error("one rising edge seen twice");

endmodule

// ---- verilog/cmpirq_top.sv ----
// register bank for the comparator pair: input select, edge irq, mirror
//
// Overview of operation
// - a set rise enable makes each low-to-high result edge set the flag.
// - a set fall enable makes each high-to-low result edge set the flag.
// - bits 1-0 of the input control route the inverting input to pin 0-3.
// - bit 0 of the mirror register always copies comparator one's result.
// - bit 1 of the mirror register copies comparator two's result.
// - mirror bits 7-2 read zero and ignore writes.
// - while enabled, the result is high when positive exceeds negative, flipped by invert; disabled, it reads low.
`timescale 1ns/1ps
module cmpirq_top #(
  parameter int NUM_CMP = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [cmpirq_pkg::ADDR_W-1:0] addr,
  input wire logic [cmpirq_pkg::DATA_W-1:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [cmpirq_pkg::DATA_W-1:0] rdata,
  input wire logic [NUM_CMP-1:0] cmp_raw,
  output logic [NUM_CMP-1:0] cmp_enable,
  output logic [NUM_CMP-1:0] cmp_pin_drive,
  output logic [NUM_CMP-1:0] cmp_low_power,
  output logic [NUM_CMP-1:0] cmp_hyst_on,
  output logic [NUM_CMP-1:0] cmp_timer_sync,
  output logic [2*NUM_CMP-1:0] pos_input_select,
  output logic [2*NUM_CMP-1:0] neg_input_select,
  output logic irq
);

  if (NUM_CMP < 1 || NUM_CMP > 2) begin : g_bad_count
    $error("comparator count must be 1 or 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // address of a per-comparator register
  function automatic logic [3:0] chan_off(input logic [3:0] base,
                                          input int idx);
    chan_off = base + 4'(idx * 2);
  endfunction

  logic [7:0] main_ff [NUM_CMP];
  logic [7:0] inirq_ff [NUM_CMP];
  logic [7:0] nxt_main [NUM_CMP];
  logic [7:0] nxt_inirq [NUM_CMP];
  logic [7:0] main_view [NUM_CMP];
  logic [NUM_CMP-1:0] main_wr;
  logic [NUM_CMP-1:0] inirq_wr;
  logic [NUM_CMP-1:0] main_rd;
  logic [NUM_CMP-1:0] inirq_rd;
  logic [NUM_CMP-1:0] cmp_result;
  logic [NUM_CMP-1:0] rise_ev;
  logic [NUM_CMP-1:0] fall_ev;
  logic [NUM_CMP-1:0] flag_set;
  logic [NUM_CMP-1:0] status_ff;
  logic [NUM_CMP-1:0] nxt_status;
  logic [NUM_CMP-1:0] status_clr;
  logic [NUM_CMP-1:0] mask_ff;
  logic [NUM_CMP-1:0] nxt_mask;
  logic irq_ff;
  logic nxt_irq;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] chan_word;
  logic [7:0] mirror_word;
  logic [7:0] status_word;
  logic [7:0] mask_word;
  logic mirror_rd;
  logic status_rd;
  logic mask_rd;
  logic status_wr;
  logic mask_wr;

  ////////////////////////////////////////////////////////////////////////
  // shared register decode
  assign mirror_rd = rd_strobe && (addr == cmpirq_pkg::OFF_MIRROR);
  assign status_rd = rd_strobe && (addr == cmpirq_pkg::OFF_STATUS);
  assign mask_rd = rd_strobe && (addr == cmpirq_pkg::OFF_MASK);
  assign status_wr = wr_strobe && (addr == cmpirq_pkg::OFF_STATUS);
  assign mask_wr = wr_strobe && (addr == cmpirq_pkg::OFF_MASK);

  ////////////////////////////////////////////////////////////////////////
  // per-comparator registers and result logic
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
    assign main_wr[i] = wr_strobe &&
      (addr == chan_off(cmpirq_pkg::OFF_MAIN1, i));
    assign inirq_wr[i] = wr_strobe &&
      (addr == chan_off(cmpirq_pkg::OFF_INIRQ1, i));
    assign main_rd[i] = rd_strobe &&
      (addr == chan_off(cmpirq_pkg::OFF_MAIN1, i));
    assign inirq_rd[i] = rd_strobe &&
      (addr == chan_off(cmpirq_pkg::OFF_INIRQ1, i));

    // result bit is not stored here; it is read live from the channel
    assign nxt_main[i] = main_wr[i] ?
      (wdata & cmpirq_pkg::MAIN_WMASK) : main_ff[i];
    assign nxt_inirq[i] = inirq_wr[i] ?
      (wdata & cmpirq_pkg::INIRQ_WMASK) : inirq_ff[i];
    assign main_view[i] = main_ff[i] |
      (8'(cmp_result[i]) << cmpirq_pkg::MAIN_RES);

    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        main_ff[i] <= cmpirq_pkg::MAIN_RST;
        inirq_ff[i] <= cmpirq_pkg::INIRQ_RST;
      end else begin
        main_ff[i] <= nxt_main[i];
        inirq_ff[i] <= nxt_inirq[i];
      end
    end

    cmpirq_channel u_chan (
      .clock(clock),
      .reset(reset),
      .raw(cmp_raw[i]),
      .enable(main_ff[i][cmpirq_pkg::MAIN_ON]),
      .invert(main_ff[i][cmpirq_pkg::MAIN_INV]),
      .result(cmp_result[i]),
      .rise(rise_ev[i]),
      .fall(fall_ev[i])
    );

    assign flag_set[i] =
      (rise_ev[i] & inirq_ff[i][cmpirq_pkg::INIRQ_RISE]) |
      (fall_ev[i] & inirq_ff[i][cmpirq_pkg::INIRQ_FALL]);

    // analog controls come straight from the register flip-flops
    assign cmp_enable[i] = main_ff[i][cmpirq_pkg::MAIN_ON];
    assign cmp_pin_drive[i] = main_ff[i][cmpirq_pkg::MAIN_OE];
    assign cmp_low_power[i] = main_ff[i][cmpirq_pkg::MAIN_SPEED];
    assign cmp_hyst_on[i] = main_ff[i][cmpirq_pkg::MAIN_HYS];
    assign cmp_timer_sync[i] = main_ff[i][cmpirq_pkg::MAIN_SYNC];
    assign pos_input_select[2*i +: 2] =
      inirq_ff[i][cmpirq_pkg::INIRQ_POS_LSB +: 2];
    assign neg_input_select[2*i +: 2] =
      inirq_ff[i][cmpirq_pkg::INIRQ_NEG_LSB +: 2];
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and line
  // an edge in the same cycle as its write-one-to-clear still sticks
  assign status_clr = status_wr ? wdata[NUM_CMP-1:0] : '0;
  assign nxt_status = (status_ff & ~status_clr) | flag_set;
  assign nxt_mask = mask_wr ? wdata[NUM_CMP-1:0] : mask_ff;
  assign nxt_irq = |(status_ff & mask_ff);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_ff <= cmpirq_pkg::STATUS_RST[NUM_CMP-1:0];
      mask_ff <= cmpirq_pkg::MASK_RST[NUM_CMP-1:0];
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path; writes to the mirror land nowhere
  assign mirror_word = 8'(cmp_result);
  assign status_word = 8'(status_ff);
  assign mask_word = 8'(mask_ff);

  always_comb begin
    chan_word = 8'h00;
    for (int k = 0; k < NUM_CMP; k++) begin
      if (main_rd[k]) begin
        chan_word = chan_word | main_view[k];
      end
      if (inirq_rd[k]) begin
        chan_word = chan_word | inirq_ff[k];
      end
    end
  end

  // unmapped addresses read zero
  assign nxt_rdata = chan_word |
    (mirror_rd ? mirror_word : cmpirq_pkg::RDATA_IDLE) |
    (status_rd ? status_word : cmpirq_pkg::RDATA_IDLE) |
    (mask_rd ? mask_word : cmpirq_pkg::RDATA_IDLE);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_ff <= cmpirq_pkg::RDATA_IDLE;
    end else begin
      rdata_ff <= rd_strobe ? nxt_rdata : cmpirq_pkg::RDATA_IDLE;
    end
  end

  assign rdata = rdata_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence edge_up_s(sig, en);
    $rose(sig) && en;
  endsequence

  sequence edge_down_s(sig, en);
    $fell(sig) && en;
  endsequence

  for (genvar j = 0; j < NUM_CMP; j++) begin : g_chk
    rise_flag_a: assert property (
      edge_up_s(cmp_result[j], inirq_ff[j][cmpirq_pkg::INIRQ_RISE])
      |=> status_ff[j])
      else $error("rising edge did not set the flag");

    rise_quiet_a: assert property (
      edge_up_s(cmp_result[j],
        !inirq_ff[j][cmpirq_pkg::INIRQ_RISE] && !status_ff[j])
      |=> !status_ff[j])
      else $error("masked rising edge set the flag");

    fall_flag_a: assert property (
      edge_down_s(cmp_result[j], inirq_ff[j][cmpirq_pkg::INIRQ_FALL])
      |=> status_ff[j])
      else $error("falling edge did not set the flag");

    fall_quiet_a: assert property (
      edge_down_s(cmp_result[j],
        !inirq_ff[j][cmpirq_pkg::INIRQ_FALL] && !status_ff[j])
      |=> !status_ff[j])
      else $error("masked falling edge set the flag");

    neg_select_a: assert property (
      inirq_wr[j] |=> neg_input_select[2*j +: 2] == $past(wdata[1:0]))
      else $error("negative input select not taken");

    pos_select_a: assert property (
      inirq_wr[j] |=> pos_input_select[2*j +: 2] == $past(wdata[5:4]))
      else $error("positive input select not taken");
  end

  mirror_copy_a: assert property (
    mirror_rd |=> rdata[NUM_CMP-1:0] == $past(cmp_result))
    else $error("mirror does not copy the results");

  mirror_upper_a: assert property (
    mirror_rd |=> rdata[7:2] == 6'h00)
    else $error("mirror upper bits not zero");

  irq_level_a: assert property (
    irq == $past(nxt_irq))
    else $error("interrupt line disagrees with status and mask");

  irq_quiet_a: assert property (
    !nxt_irq |=> !irq)
    else $error("interrupt line high with no unmasked flag");

  rdata_idle_a: assert property (
    !rd_strobe |=> rdata == cmpirq_pkg::RDATA_IDLE)
    else $error("read data not idle outside a read");

  unmapped_read_a: assert property (
    rd_strobe && addr > cmpirq_pkg::OFF_MASK
    |=> rdata == cmpirq_pkg::RDATA_IDLE)
    else $error("unmapped address did not read zero");

  status_read_a: assert property (
    status_rd |=> rdata == $past(status_word))
    else $error("status read does not match the flags");

  mask_read_a: assert property (
    mask_rd |=> rdata == $past(mask_word))
    else $error("mask read does not match the mask");

  spare_read_a: assert property (
    status_rd || mask_rd |=> rdata[7:2] == 6'h00)
    else $error("unused status or mask bits read high");

  mask_write_a: assert property (
    mask_wr |=> mask_ff == $past(wdata[NUM_CMP-1:0]))
    else $error("mask write not taken");

  mask_hold_a: assert property (
    !mask_wr |=> $stable(mask_ff))
    else $error("mask changed without a write");

  ////////////////////////////////////////////////////////////////////////
  // an unmasked flag must reach the line one edge after it lands
  sequence flag_raised_s(set, en);
    set && en ##1 en;
  endsequence

  for (genvar j = 0; j < NUM_CMP; j++) begin : g_reg
    main_write_a: assert property (
      main_wr[j] |=> main_ff[j] ==
        ($past(wdata) & cmpirq_pkg::MAIN_WMASK))
      else $error("main control write not taken");

    main_hold_a: assert property (
      !main_wr[j] |=> $stable(main_ff[j]))
      else $error("main control changed without a write");

    main_spare_a: assert property (
      (main_ff[j] & ~cmpirq_pkg::MAIN_WMASK) == 8'h00)
      else $error("unwritable main control bits set");

    inirq_hold_a: assert property (
      !inirq_wr[j] |=> $stable(inirq_ff[j]))
      else $error("input control changed without a write");

    inirq_spare_a: assert property (
      (inirq_ff[j] & ~cmpirq_pkg::INIRQ_WMASK) == 8'h00)
      else $error("unimplemented input control bits set");

    main_read_a: assert property (
      main_rd[j] |=> rdata == $past(main_view[j]))
      else $error("main control read wrong");

    inirq_read_a: assert property (
      inirq_rd[j] |=> rdata == $past(inirq_ff[j]))
      else $error("input control read wrong");

    flag_wins_a: assert property (
      flag_set[j] && status_wr && wdata[j] |=> status_ff[j])
      else $error("same-cycle clear beat a new edge");

    flag_clear_a: assert property (
      status_wr && wdata[j] && !flag_set[j] |=> !status_ff[j])
      else $error("write one did not clear the flag");

    flag_sticky_a: assert property (
      status_ff[j] && !(status_wr && wdata[j]) |=> status_ff[j])
      else $error("flag dropped without a clear");

    flag_quiet_a: assert property (
      !flag_set[j] && !status_ff[j] |=> !status_ff[j])
      else $error("flag set with no enabled edge");

    irq_path_a: assert property (
      flag_raised_s(flag_set[j], mask_ff[j]) |=> irq)
      else $error("unmasked flag did not raise the line");

    disabled_low_a: assert property (
      !main_ff[j][cmpirq_pkg::MAIN_ON] |=> !cmp_result[j])
      else $error("disabled comparator reads high");
  end

endmodule

// ---- testbench/cmpirq_top_test.sv ----
// self-checking bench for the comparator register bank
`timescale 1ns/1ps
module cmpirq_top_test;
  logic clock;
  logic reset;
  logic [cmpirq_pkg::ADDR_W-1:0] addr;
  logic [cmpirq_pkg::DATA_W-1:0] wdata;
  logic wr_strobe;
  logic rd_strobe;
  logic [cmpirq_pkg::DATA_W-1:0] rdata;
  logic [1:0] cmp_raw;
  logic [3:0] pos_input_select;
  logic [3:0] neg_input_select;
  logic [1:0] cmp_enable;
  logic [1:0] cmp_pin_drive;
  logic [1:0] cmp_low_power;
  logic [1:0] cmp_hyst_on;
  logic [1:0] cmp_timer_sync;
  logic irq;
  int mismatches;
  int cmp_count;
  logic [7:0] d;
  logic [1:0] inv;
  logic [1:0] raw;

  cmpirq_top #(.NUM_CMP(2)) cmpirq_top_i (
    .clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
    .cmp_pin_drive(cmp_pin_drive), .cmp_low_power(cmp_low_power),
    .cmp_hyst_on(cmp_hyst_on), .cmp_timer_sync(cmp_timer_sync),
    .pos_input_select(pos_input_select),
    .neg_input_select(neg_input_select), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // settle one step past the edge so sampled outputs are final
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [3:0] ia(input int c);
    return cmpirq_pkg::OFF_INIRQ1 + 4'(c) * cmpirq_pkg::OFF_STRIDE;
  endfunction

  function automatic logic [3:0] ma(input int c);
    return cmpirq_pkg::OFF_MAIN1 + 4'(c) * cmpirq_pkg::OFF_STRIDE;
  endfunction

  function automatic logic [7:0] exp_main(input logic i, input logic r);
    return {1'b1, r ^ i, 1'b0, i, 4'h0};
  endfunction

  // result bit reads live: enable and polarity applied to the input
  function automatic logic [7:0] exp_ctl(input logic [7:0] v,
                                         input logic r);
    return (v & cmpirq_pkg::MAIN_WMASK) | {1'b0, v[7] & (r ^ v[4]), 6'h00};
  endfunction

  function automatic logic [7:0] exp_mirror(input logic [1:0] r,
                                            input logic [1:0] i);
    return {6'h00, r ^ i};
  endfunction

  ////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // whole run needs under six hundred cycles; twenty thousand is ample
  initial begin
    #(50 * 20000);
    mismatches++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    cmp_raw = 2'b00;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(26));
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) rd(4'(a), 8'h00);
    $display("reset values test done");
    for (int k = 0; k < 16; k++) begin
      d = (k < 2) ? 8'hFF : 8'($urandom);
      wr(ia(k % 2), d);
      rd(ia(k % 2), d & cmpirq_pkg::INIRQ_WMASK);
      chk({6'h0, neg_input_select[2*(k%2) +: 2]}, {6'h0, d[1:0]});
      chk({6'h0, pos_input_select[2*(k%2) +: 2]}, {6'h0, d[5:4]});
    end
    $display("input select test done");
    for (int k = 0; k < 12; k++) begin
      inv = 2'($urandom);
      raw = 2'($urandom);
      wr(ma(0), {3'h4, inv[0], 4'h0});
      wr(ma(1), {3'h4, inv[1], 4'h0});
      @(posedge clock);
      cmp_raw <= raw;
      tick(2);
      wr(cmpirq_pkg::OFF_MIRROR, 8'hFF);
      rd(cmpirq_pkg::OFF_MIRROR, exp_mirror(raw, inv));
      rd(ma(1), exp_main(inv[1], raw[1]));
    end
    $display("mirror test done");
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom);
      raw = 2'($urandom);
      @(posedge clock);
      cmp_raw <= raw;
      wr(ma(k % 2), d);
      rd(ma(k % 2), exp_ctl(d, raw[k % 2]));
      chk({3'h0, cmp_enable[k%2], cmp_pin_drive[k%2],
        cmp_low_power[k%2], cmp_hyst_on[k%2], cmp_timer_sync[k%2]},
        {3'h0, d[7], d[5], d[2], d[1], d[0]});
    end
    $display("main control test done");
    wr(cmpirq_pkg::OFF_MASK, 8'hFF);
    rd(cmpirq_pkg::OFF_MASK, 8'h03);
    wr(ma(0), 8'h80);
    wr(ma(1), 8'h80);
    @(posedge clock);
    cmp_raw <= 2'b00;
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        wr(ia(c), {2'(m), 6'h00});
        tick(3);
        wr(cmpirq_pkg::OFF_STATUS, 8'hFF);
        @(posedge clock);
        cmp_raw[c] <= 1'b1;
        tick(4);
        chk({7'h0, irq}, {7'h0, m[1]});
        rd(cmpirq_pkg::OFF_STATUS, {6'h0, 2'(m[1]) << c});
        wr(cmpirq_pkg::OFF_STATUS, 8'hFF);
        tick(2);
        rd(cmpirq_pkg::OFF_STATUS, 8'h00);
        chk({7'h0, irq}, 8'h00);
        @(posedge clock);
        cmp_raw[c] <= 1'b0;
        tick(4);
        rd(cmpirq_pkg::OFF_STATUS, {6'h0, 2'(m[0]) << c});
        wr(cmpirq_pkg::OFF_STATUS, 8'hFF);
      end
    end
    $display("edge flag test done");
    wr(cmpirq_pkg::OFF_MASK, 8'h00);
    wr(ia(0), 8'hC0);
    @(posedge clock);
    cmp_raw[0] <= 1'b1;
    tick(4);
    chk({7'h0, irq}, 8'h00);
    wr(cmpirq_pkg::OFF_MASK, 8'h01);
    tick(2);
    chk({7'h0, irq}, 8'h01);
    $display("mask test done");
    stop_test();
  end
endmodule
